// file: dpa_pkg.sv
// Purpose: Shared constants for the port pin assignment block
// Assumes: 10 MHz system clock
// Notes:   Config registers are byte wide
`default_nettype none
package dpa_pkg;
  localparam logic [7:0] REG_PULSE_DEBOUNCE = 8'h1B;
  localparam logic [7:0] REG_LATCH_MASK     = 8'h1D;
  localparam logic [7:0] REG_IRQ_ROUTING    = 8'h1E;
  localparam logic [7:0] REG_DIR_PULLUP     = 8'h21;

  localparam logic [7:0] RST_PULSE_DEBOUNCE = 8'h00;
  localparam logic [7:0] RST_LATCH_MASK     = 8'h00;
  localparam logic [7:0] RST_IRQ_ROUTING    = 8'h00;
  localparam logic [7:0] RST_DIR_PULLUP     = 8'hF0;

  localparam int PULSE_A_SEL_BIT  = 0;
  localparam int PULSE_B_SEL_BIT  = 1;
  localparam int DEB_EN_LINE0_BIT = 6;
  localparam int DEB_EN_LINE1_BIT = 7;
  localparam int LATCH_MASK_LSB   = 0;
  localparam int IRQ_LINE4_BIT    = 6;
  localparam int IRQ_LINE5_BIT    = 7;
  localparam int DIR_LSB          = 4;
  localparam int PULLUP_LSB       = 0;

  localparam logic LINE_IDLE_LEVEL = 1'b1;

  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned DEBOUNCE_TIME_MS = 40;
  localparam int unsigned DEBOUNCE_CYCLES  = (DEBOUNCE_TIME_MS * (CLK_HZ / 1000));
endpackage
`default_nettype wire

// file: dpa_debounce.sv
// Purpose: Monoflop debounce for one port input line
// Assumes: Input synchronous to clk
// Notes:   Disabled filter passes the line through with one flop
`timescale 1ns/100ps
`default_nettype none
module dpa_debounce #(
  parameter int unsigned HOLD_CYCLES = dpa_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic raw_in,
  output var  logic level_out
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);

  logic [CW-1:0] hold_count;
  logic [CW-1:0] next_hold_count;
  logic          next_level;

  always_comb begin
    next_level      = level_out;
    next_hold_count = hold_count;
    if (!enable) begin
      next_level      = raw_in;
      next_hold_count = '0;
    end else if (hold_count != '0) begin
      next_hold_count = hold_count - 1'b1;
    end else if (raw_in != level_out) begin
      next_level      = raw_in;
      next_hold_count = CW'(HOLD_CYCLES);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_out  <= dpa_pkg::LINE_IDLE_LEVEL;
      hold_count <= '0;
    end else begin
      level_out  <= next_level;
      hold_count <= next_hold_count;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_hold_window: assert property ((enable && hold_count != '0) ##1 enable |-> $stable(level_out))
    else $error("debounce output changed inside hold window");
  a_follow_raw: assert property (!enable |=> level_out == $past(raw_in))
    else $error("disabled debounce does not follow input");
endmodule
`default_nettype wire

// file: dpa_trigger_latch.sv
// Purpose: Falling edge trigger latch for one port line
// Assumes: Line level already filtered
// Notes:   Clear bit held high clears latch, but an armed falling edge still sets it
`timescale 1ns/100ps
`default_nettype none
module dpa_trigger_latch (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic arm,
  input  wire logic line_level,
  input  wire logic clear_bit,
  output var  logic latched
);
  logic prev_level;
  logic next_latched;
  logic fall;

  always_comb begin
    fall         = prev_level & ~line_level;
    next_latched = (arm & fall) | (latched & ~clear_bit);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_level <= dpa_pkg::LINE_IDLE_LEVEL;
      latched    <= 1'b0;
    end else begin
      prev_level <= line_level;
      latched    <= next_latched;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_latch_set: assert property (arm && prev_level && !line_level |=> latched)
    else $error("armed falling edge not latched");
  a_latch_hold: assert property (latched && !clear_bit |=> latched)
    else $error("latch dropped without clear");
  a_latch_unarmed: assert property (!latched && !arm |=> !latched)
    else $error("unarmed latch set");
endmodule
`default_nettype wire

// file: dpa_pin_mux.sv
// Purpose: Port pin assignment between DSP bits, latches, pulse codes and interrupt
// Assumes: Config written over the serial interface byte port; inputs synchronous
// Notes:   Pin outputs and enables are registered
//
// Summary of operation
// - Each port pin is routed to DSP bits, latches, pulse or interrupt.
// - Only lines 0 to 3 have debounce and pull-up options.
// - Enabled debounce ignores input changes about 40 ms after accepted change.
// - Debounce enable bit 6 serves lines 0 and 2, bit 7 serves lines 1 and 3.
// - First pulse code goes to line 0 when select is 0, line 2 otherwise.
// - Second pulse code goes to line 1 when select is 0, line 3 otherwise.
// - Four-bit mask arms the trigger latch of lines 0 to 3.
// - Routing bit 6 puts the active-low interrupt on line 4.
// - Routing bit 7 puts the active-low interrupt on line 5.
// - Direction bits 4 to 7 make lines 0 to 3 output at 0.
// - Pull-up bits 0 to 3 enable pull-ups of lines 0 to 3.
// - DSP bit 2 or 3 must stay clear for pulse to reach pin.
// - Interrupt released by slave select rise or stop; level readable as flag.
// - A set latch stays until its DSP output bit is set, which clears it on the next clock.
`timescale 1ns/100ps
`default_nettype none
module dpa_pin_mux #(
  parameter int unsigned DEBOUNCE_CYCLES = dpa_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       cfg_wr_en,
  input  wire logic       cfg_rd_en,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wr_data,
  output var  logic [7:0] cfg_rd_data,
  input  wire logic [5:0] port_in,
  output var  logic [5:0] port_out,
  output var  logic [5:0] port_oe,
  output var  logic [3:0] port_pullup_enable,
  input  wire logic [5:0] dsp_out_bits,
  output wire logic [3:0] dsp_in_bits,
  output wire logic [3:0] trigger_latch,
  input  wire logic       pulse_code_out_a,
  input  wire logic       pulse_code_out_b,
  input  wire logic       pulse_a_active,
  input  wire logic       pulse_b_active,
  input  wire logic       irq_set,
  input  wire logic       i2c_stop,
  output wire logic       interrupt_in_flag,
  input  wire logic       spi_mode,
  input  wire logic       spi_miso,
  output var  logic       spi_ssn
);
  logic [7:0] port_pulse_debounce_config;
  logic [7:0] trigger_latch_mask_config;
  logic [7:0] interrupt_pin_routing_config;
  logic [7:0] port_direction_pullup_config;
  logic [7:0] next_pulse_debounce;
  logic [7:0] next_latch_mask;
  logic [7:0] next_irq_routing;
  logic [7:0] next_dir_pullup;
  logic [7:0] next_rd_data;
  logic [5:0] next_port_out;
  logic [5:0] next_port_oe;
  logic       interrupt_out_n;
  logic       next_interrupt_out_n;
  logic       ssn_rise;
  logic [3:0] debounce_enable;
  logic [3:0] port_direction;
  logic [3:0] latch_input_mask;
  logic       pulse_a_route_sel;
  logic       pulse_b_route_sel;
  logic       irq_on_line4_enable;
  logic       irq_on_line5_enable;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    reg_hit = (addr == offset);
  endfunction

  always_comb begin
    pulse_a_route_sel   = port_pulse_debounce_config[dpa_pkg::PULSE_A_SEL_BIT];
    pulse_b_route_sel   = port_pulse_debounce_config[dpa_pkg::PULSE_B_SEL_BIT];
    debounce_enable[0]  = port_pulse_debounce_config[dpa_pkg::DEB_EN_LINE0_BIT];
    debounce_enable[1]  = port_pulse_debounce_config[dpa_pkg::DEB_EN_LINE1_BIT];
    debounce_enable[2]  = port_pulse_debounce_config[dpa_pkg::DEB_EN_LINE0_BIT];
    debounce_enable[3]  = port_pulse_debounce_config[dpa_pkg::DEB_EN_LINE1_BIT];
    latch_input_mask    = trigger_latch_mask_config[dpa_pkg::LATCH_MASK_LSB +: 4];
    irq_on_line4_enable = interrupt_pin_routing_config[dpa_pkg::IRQ_LINE4_BIT];
    irq_on_line5_enable = interrupt_pin_routing_config[dpa_pkg::IRQ_LINE5_BIT];
    port_direction      = port_direction_pullup_config[dpa_pkg::DIR_LSB +: 4];
  end

  // Configuration register write and read
  always_comb begin
    next_pulse_debounce = port_pulse_debounce_config;
    next_latch_mask     = trigger_latch_mask_config;
    next_irq_routing    = interrupt_pin_routing_config;
    next_dir_pullup     = port_direction_pullup_config;
    next_rd_data        = cfg_rd_data;
    if (cfg_wr_en) begin
      if (reg_hit(cfg_addr, dpa_pkg::REG_PULSE_DEBOUNCE)) next_pulse_debounce = cfg_wr_data;
      if (reg_hit(cfg_addr, dpa_pkg::REG_LATCH_MASK))     next_latch_mask     = cfg_wr_data;
      if (reg_hit(cfg_addr, dpa_pkg::REG_IRQ_ROUTING))    next_irq_routing    = cfg_wr_data;
      if (reg_hit(cfg_addr, dpa_pkg::REG_DIR_PULLUP))     next_dir_pullup     = cfg_wr_data;
    end
    if (cfg_rd_en) begin
      next_rd_data = 8'h00;
      if (reg_hit(cfg_addr, dpa_pkg::REG_PULSE_DEBOUNCE)) next_rd_data = port_pulse_debounce_config;
      if (reg_hit(cfg_addr, dpa_pkg::REG_LATCH_MASK))     next_rd_data = trigger_latch_mask_config;
      if (reg_hit(cfg_addr, dpa_pkg::REG_IRQ_ROUTING))    next_rd_data = interrupt_pin_routing_config;
      if (reg_hit(cfg_addr, dpa_pkg::REG_DIR_PULLUP))     next_rd_data = port_direction_pullup_config;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_pulse_debounce_config   <= dpa_pkg::RST_PULSE_DEBOUNCE;
      trigger_latch_mask_config    <= dpa_pkg::RST_LATCH_MASK;
      interrupt_pin_routing_config <= dpa_pkg::RST_IRQ_ROUTING;
      port_direction_pullup_config <= dpa_pkg::RST_DIR_PULLUP;
      cfg_rd_data                  <= 8'h00;
      port_pullup_enable           <= 4'h0;
    end else begin
      port_pulse_debounce_config   <= next_pulse_debounce;
      trigger_latch_mask_config    <= next_latch_mask;
      interrupt_pin_routing_config <= next_irq_routing;
      port_direction_pullup_config <= next_dir_pullup;
      cfg_rd_data                  <= next_rd_data;
      port_pullup_enable           <= next_dir_pullup[dpa_pkg::PULLUP_LSB +: 4];
    end
  end

  // Input filters and trigger latches on the lower four lines
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lower_line
      dpa_debounce #(
        .HOLD_CYCLES (DEBOUNCE_CYCLES)
      ) u_debounce (
        .clk       (clk),
        .reset     (reset),
        .enable    (debounce_enable[g]),
        .raw_in    (port_in[g]),
        .level_out (dsp_in_bits[g])
      );
      dpa_trigger_latch u_latch (
        .clk        (clk),
        .reset      (reset),
        .arm        (latch_input_mask[g]),
        .line_level (dsp_in_bits[g]),
        .clear_bit  (dsp_out_bits[g]),
        .latched    (trigger_latch[g])
      );
    end
  endgenerate

  // Interrupt level, set wins over release
  always_comb begin
    ssn_rise             = spi_mode & port_in[0] & ~spi_ssn;
    next_interrupt_out_n = interrupt_out_n;
    if (irq_set) begin
      next_interrupt_out_n = 1'b0;
    end else if (ssn_rise || i2c_stop) begin
      next_interrupt_out_n = 1'b1;
    end
  end

  assign interrupt_in_flag = interrupt_out_n;

  // Pin output routing
  always_comb begin
    next_port_out = 6'h00;
    next_port_oe  = 6'h00;
    for (int i = 0; i < 4; i++) begin
      next_port_out[i] = dsp_out_bits[i];
      next_port_oe[i]  = ~port_direction[i];
    end
    if (pulse_a_active) begin
      if (pulse_a_route_sel) begin
        next_port_out[2] = pulse_code_out_a | dsp_out_bits[2];
        next_port_oe[2]  = 1'b1;
      end else begin
        next_port_out[0] = pulse_code_out_a;
        next_port_oe[0]  = 1'b1;
      end
    end
    if (pulse_b_active) begin
      if (pulse_b_route_sel) begin
        next_port_out[3] = pulse_code_out_b | dsp_out_bits[3];
        next_port_oe[3]  = 1'b1;
      end else begin
        next_port_out[1] = pulse_code_out_b;
        next_port_oe[1]  = 1'b1;
      end
    end
    next_port_out[4] = irq_on_line4_enable ? interrupt_out_n : dsp_out_bits[4];
    next_port_out[5] = irq_on_line5_enable ? interrupt_out_n : dsp_out_bits[5];
    next_port_oe[4]  = 1'b1;
    next_port_oe[5]  = 1'b1;
    if (spi_mode) begin
      next_port_out[0] = 1'b0;
      next_port_oe[0]  = 1'b0;
      next_port_out[1] = spi_miso;
      next_port_oe[1]  = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_out        <= 6'h00;
      port_oe         <= 6'h30;
      interrupt_out_n <= 1'b1;
      spi_ssn         <= 1'b1;
    end else begin
      port_out        <= next_port_out;
      port_oe         <= next_port_oe;
      interrupt_out_n <= next_interrupt_out_n;
      spi_ssn         <= port_in[0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_irq_assert: assert property (irq_set |=> !interrupt_in_flag)
    else $error("interrupt not asserted after set");
  a_irq_release: assert property (!irq_set && (i2c_stop || ssn_rise) |=> interrupt_in_flag)
    else $error("interrupt not released");
  a_line4_irq: assert property (irq_on_line4_enable |=> port_out[4] == $past(interrupt_out_n))
    else $error("line 4 not carrying interrupt");
  a_line5_irq: assert property (irq_on_line5_enable |=> port_out[5] == $past(interrupt_out_n))
    else $error("line 5 not carrying interrupt");
  a_line45_dsp: assert property (!irq_on_line4_enable && !irq_on_line5_enable
      |=> port_oe[5:4] == 2'b11 && port_out[5:4] == $past(dsp_out_bits[5:4]))
    else $error("lines 4 and 5 not driving DSP bits");
  a_pulse_a_line2: assert property (pulse_a_active && pulse_a_route_sel
      |=> port_oe[2] && port_out[2] == $past(pulse_code_out_a | dsp_out_bits[2]))
    else $error("first pulse code missing on line 2");
  a_pulse_a_line0: assert property (pulse_a_active && !pulse_a_route_sel && !spi_mode
      |=> port_oe[0] && port_out[0] == $past(pulse_code_out_a))
    else $error("first pulse code missing on line 0");
  a_pulse_b_line3: assert property (pulse_b_active && pulse_b_route_sel
      |=> port_oe[3] && port_out[3] == $past(pulse_code_out_b | dsp_out_bits[3]))
    else $error("second pulse code missing on line 3");
  a_dir_line3: assert property (!(pulse_b_active && pulse_b_route_sel)
      |=> port_oe[3] == !$past(port_direction[3]))
    else $error("line 3 direction wrong");
  a_spi_pins: assert property (spi_mode |=> !port_oe[0] && port_oe[1]
      && port_out[1] == $past(spi_miso))
    else $error("SPI pin override wrong");
  a_pullup_write: assert property (cfg_wr_en && cfg_addr == dpa_pkg::REG_DIR_PULLUP
      |=> port_pullup_enable == $past(cfg_wr_data[3:0]))
    else $error("pull-up enables not updated");
  a_debounce_map: assert property (cfg_wr_en && cfg_addr == dpa_pkg::REG_PULSE_DEBOUNCE
      |=> debounce_enable[1:0] == $past(cfg_wr_data[7:6]))
    else $error("debounce enable mapping wrong");


  // Routing, register and pin checks
  a_pulse_b_line1: assert property (pulse_b_active && !pulse_b_route_sel && !spi_mode
      |=> port_oe[1] && port_out[1] == $past(pulse_code_out_b))
    else $error("second pulse code missing on line 1");
  a_set_wins: assert property (irq_set && i2c_stop |=> !interrupt_in_flag)
    else $error("release won over set");
  a_flag_hold: assert property (!irq_set && !i2c_stop && !ssn_rise
      |=> interrupt_in_flag == $past(interrupt_in_flag))
    else $error("interrupt level changed without event");
  a_ssn_copy: assert property (1'b1 |=> spi_ssn == $past(port_in[0]))
    else $error("slave select sample wrong");
  a_oe_upper: assert property (port_oe[5:4] == 2'b11)
    else $error("lines 4 and 5 not driven");
  a_line4_dsp: assert property (!irq_on_line4_enable
      |=> port_out[4] == $past(dsp_out_bits[4]))
    else $error("line 4 not carrying DSP bit");
  a_line5_dsp: assert property (!irq_on_line5_enable
      |=> port_out[5] == $past(dsp_out_bits[5]))
    else $error("line 5 not carrying DSP bit");
  a_lower_dsp: assert property (!pulse_a_active && !pulse_b_active && !spi_mode
      |=> port_out[3:0] == $past(dsp_out_bits[3:0]))
    else $error("lower lines not carrying DSP bits");
  a_rd_mask: assert property (cfg_rd_en && cfg_addr == dpa_pkg::REG_LATCH_MASK
      |=> cfg_rd_data == $past(trigger_latch_mask_config))
    else $error("latch mask read back wrong");
  a_rd_unmapped: assert property (cfg_rd_en
      && !reg_hit(cfg_addr, dpa_pkg::REG_PULSE_DEBOUNCE)
      && !reg_hit(cfg_addr, dpa_pkg::REG_LATCH_MASK)
      && !reg_hit(cfg_addr, dpa_pkg::REG_IRQ_ROUTING)
      && !reg_hit(cfg_addr, dpa_pkg::REG_DIR_PULLUP) |=> cfg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!cfg_rd_en |=> $stable(cfg_rd_data))
    else $error("read data changed without read");
  a_pullup_hold: assert property (!(cfg_wr_en && cfg_addr == dpa_pkg::REG_DIR_PULLUP)
      |=> $stable(port_pullup_enable))
    else $error("pull-up enables changed without write");

  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_dir_check
      a_dir_lower: assert property (!pulse_a_active && !pulse_b_active && !spi_mode
          |=> port_oe[k] == !$past(port_direction[k]))
        else $error("lower line direction wrong");
    end
  endgenerate

  c_pulse_line2: cover property (pulse_a_active && pulse_a_route_sel ##1 port_oe[2]);
  c_irq_line5: cover property (irq_on_line5_enable && irq_set ##[1:20] i2c_stop);
  c_latch_set: cover property (!trigger_latch[0] ##1 trigger_latch[0]);
  c_spi_release: cover property (!interrupt_out_n && ssn_rise);
  c_debounce_held: cover property (debounce_enable[1] && port_in[1] != dsp_in_bits[1]);
endmodule
`default_nettype wire

// file: dpa_port_model.sv
// Purpose: Model of the switches and circuitry on the six port lines
// Assumes: Bench decides per line whether a switch drives it
// Notes:   Undriven lines without pull-up toggle every cycle
`timescale 1ns/100ps
`default_nettype none
module dpa_port_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [5:0] port_out,
  input  wire logic [5:0] port_oe,
  input  wire logic [3:0] port_pullup_enable,
  input  wire logic [5:0] sw_drive,
  input  wire logic [5:0] sw_val,
  output var  logic [5:0] port_in
);
  logic       flip;
  logic [5:0] pu6;

  assign pu6 = {2'b00, port_pullup_enable};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
    end
  end

  // Wire level from all parties on each line
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (port_oe[i]) begin
        port_in[i] = port_out[i];
      end else if (sw_drive[i]) begin
        port_in[i] = sw_val[i];
      end else if (pu6[i]) begin
        port_in[i] = 1'b1;
      end else begin
        port_in[i] = flip ^ i[0];
      end
    end
  end
endmodule
`default_nettype wire

// file: dsp_port_pin_assignment_test.sv
// Purpose: Self-checking bench for the port pin assignment block
// Assumes: Debounce window shortened to 16 cycles
// Notes:   Inputs driven by non-blocking assignment at the rising edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module dsp_port_pin_assignment_test;
  localparam int unsigned DEB = 16;
  logic       clk = 1'b0, reset = 1'b1, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0;
  logic [7:0] cfg_addr = 8'h00, cfg_wr_data = 8'h00, cfg_rd_data;
  logic [5:0] port_in, port_out, port_oe, dsp_out_bits = 6'h00;
  logic [5:0] sw_drive = 6'h00, sw_val = 6'h3F;
  logic [3:0] port_pullup_enable, dsp_in_bits, trigger_latch;
  logic       pulse_code_out_a = 1'b0, pulse_code_out_b = 1'b0;
  logic       pulse_a_active = 1'b0, pulse_b_active = 1'b0, irq_set = 1'b0;
  logic       i2c_stop = 1'b0, spi_mode = 1'b0, spi_miso = 1'b0;
  logic       interrupt_in_flag, spi_ssn;
  int         num_errors = 0, n_tests = 0, cycles = 0;

  dpa_pin_mux #(.DEBOUNCE_CYCLES(DEB)) uut (
    .clk(clk), .reset(reset), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .port_pullup_enable(port_pullup_enable), .dsp_out_bits(dsp_out_bits),
    .dsp_in_bits(dsp_in_bits), .trigger_latch(trigger_latch),
    .pulse_code_out_a(pulse_code_out_a), .pulse_code_out_b(pulse_code_out_b),
    .pulse_a_active(pulse_a_active), .pulse_b_active(pulse_b_active),
    .irq_set(irq_set), .i2c_stop(i2c_stop), .interrupt_in_flag(interrupt_in_flag),
    .spi_mode(spi_mode), .spi_miso(spi_miso), .spi_ssn(spi_ssn));

  dpa_port_model ext (
    .clk(clk), .reset(reset), .port_out(port_out), .port_oe(port_oe),
    .port_pullup_enable(port_pullup_enable), .sw_drive(sw_drive),
    .sw_val(sw_val), .port_in(port_in));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr_en <= 1'b1;
    cfg_addr <= a;
    cfg_wr_data <= d;
    @(posedge clk);
    cfg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    cfg_rd_en <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd_en <= 1'b0;
    #1;
    d = cfg_rd_data;
  endtask

  task automatic pulse_in(input int which);
    @(posedge clk);
    if (which == 0) irq_set <= 1'b1; else i2c_stop <= 1'b1;
    @(posedge clk);
    irq_set <= 1'b0;
    i2c_stop <= 1'b0;
  endtask

  task automatic t_regs();
    logic [7:0] addrs [4];
    logic [7:0] rsts [4];
    logic [7:0] d;
    addrs = '{dpa_pkg::REG_PULSE_DEBOUNCE, dpa_pkg::REG_LATCH_MASK,
              dpa_pkg::REG_IRQ_ROUTING, dpa_pkg::REG_DIR_PULLUP};
    rsts = '{dpa_pkg::RST_PULSE_DEBOUNCE, dpa_pkg::RST_LATCH_MASK,
             dpa_pkg::RST_IRQ_ROUTING, dpa_pkg::RST_DIR_PULLUP};
    `CHK(port_oe, 6'h30)
    `CHK(interrupt_in_flag, 1'b1)
    for (int i = 0; i < 4; i++) begin
      rd(addrs[i], d);
      `CHK(d, rsts[i])
      wr(addrs[i], 8'hA5);
      rd(addrs[i], d);
      `CHK(d, 8'hA5)
    end
    wr(8'h1C, 8'hFF);
    rd(8'h1C, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_dir_pullup();
    wr(dpa_pkg::REG_PULSE_DEBOUNCE, 8'h00);
    wr(dpa_pkg::REG_IRQ_ROUTING, 8'h00);
    wr(dpa_pkg::REG_DIR_PULLUP, 8'h5A);
    @(posedge clk);
    dsp_out_bits <= 6'h1A;
    step(3);
    `CHK(port_oe, 6'h3A)
    `CHK(port_out[5:0] & 6'h3A, 6'h1A)
    `CHK(port_pullup_enable, 4'hA)
  endtask

  task automatic t_pulse();
    int la, lb;
    wr(dpa_pkg::REG_DIR_PULLUP, 8'hF0);
    for (int s = 0; s < 2; s++) begin
      la = s ? 2 : 0;
      lb = s ? 3 : 1;
      wr(dpa_pkg::REG_PULSE_DEBOUNCE, {6'h00, s[0], s[0]});
      @(posedge clk);
      dsp_out_bits <= 6'h00;
      {pulse_a_active, pulse_b_active} <= 2'b11;
      {pulse_code_out_a, pulse_code_out_b} <= 2'b10;
      step(3);
      `CHK({port_oe[la], port_out[la]}, 2'b11)
      `CHK({port_oe[lb], port_out[lb]}, 2'b10)
      `CHK(port_oe[s ? 0 : 2], 1'b0)
      @(posedge clk);
      {pulse_code_out_a, pulse_code_out_b} <= 2'b01;
      step(3);
      `CHK({port_out[la], port_out[lb]}, 2'b01)
    end
    @(posedge clk);
    {pulse_a_active, pulse_b_active} <= 2'b00;
  endtask

  task automatic t_debounce();
    @(posedge clk);
    sw_drive <= 6'h0F;
    sw_val <= 6'h3F;
    wr(dpa_pkg::REG_DIR_PULLUP, 8'hF0);
    wr(dpa_pkg::REG_PULSE_DEBOUNCE, 8'h80);
    step(DEB + 4);
    @(posedge clk);
    sw_val[1:0] <= 2'b00;
    step(3);
    @(posedge clk);
    sw_val[1:0] <= 2'b11;
    step(3);
    `CHK(dsp_in_bits[1:0], 2'b01)
    wr(dpa_pkg::REG_PULSE_DEBOUNCE, 8'h40);
    step(DEB + 4);
    @(posedge clk);
    sw_val[1:0] <= 2'b00;
    step(3);
    `CHK(dsp_in_bits[1:0], 2'b00)
    @(posedge clk);
    sw_val[1:0] <= 2'b11;
    step(3);
    `CHK(dsp_in_bits[1:0], 2'b10)
    step(DEB + 2);
    `CHK(dsp_in_bits[1:0], 2'b11)
  endtask

  task automatic t_latch();
    wr(dpa_pkg::REG_LATCH_MASK, 8'h04);
    @(posedge clk);
    dsp_out_bits[3:0] <= 4'hF;
    step(2);
    @(posedge clk);
    dsp_out_bits[3:0] <= 4'h0;
    step(2);
    `CHK(trigger_latch, 4'h0)
    @(posedge clk);
    sw_val[3:2] <= 2'b00;
    step(4);
    `CHK(trigger_latch, 4'h4)
    @(posedge clk);
    sw_val[3:2] <= 2'b11;
    step(DEB + 4);
    `CHK(trigger_latch, 4'h4)
    @(posedge clk);
    dsp_out_bits[2] <= 1'b1;
    step(3);
    @(posedge clk);
    dsp_out_bits[2] <= 1'b0;
    step(3);
    `CHK(trigger_latch, 4'h0)
  endtask

  task automatic t_irq();
    wr(dpa_pkg::REG_IRQ_ROUTING, 8'h40);
    @(posedge clk);
    dsp_out_bits <= 6'h00;
    pulse_in(0);
    step(2);
    `CHK({interrupt_in_flag, port_out[5:4]}, 3'b000)
    pulse_in(1);
    step(2);
    `CHK({interrupt_in_flag, port_out[5:4]}, 3'b101)
    wr(dpa_pkg::REG_IRQ_ROUTING, 8'h80);
    @(posedge clk);
    dsp_out_bits <= 6'h10;
    pulse_in(0);
    step(2);
    `CHK({interrupt_in_flag, port_out[5:4]}, 3'b001)
    @(posedge clk);
    sw_val[0] <= 1'b0;
    spi_mode <= 1'b1;
    spi_miso <= 1'b1;
    step(3);
    `CHK({spi_ssn, port_oe[1:0], port_out[1]}, 4'b0101)
    `CHK(interrupt_in_flag, 1'b0)
    @(posedge clk);
    sw_val[0] <= 1'b1;
    step(3);
    `CHK({spi_ssn, interrupt_in_flag}, 2'b11)
  endtask

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    step(1);
    t_regs();
    t_dir_pullup();
    t_pulse();
    t_debounce();
    t_latch();
    t_irq();
    results();
  end
endmodule
`default_nettype wire
